// ---- bench/hpg_card.sv ----
/*
  slot card model: each rail comes up one clock after its enable and drops on
  command; fault detector flags follow the bench commands.
  assumes one clock shared with the block under test.
*/
`timescale 1ns/1ns
module hpg_card (
  // clock
  input wire logic clock_i,
  // enables and commands from the bench
  input wire logic [1:0] main_enable_i,
  input wire logic [1:0] aux_enable_i,
  input wire logic [5:0] drop_i,
  input wire logic [1:0] main_fault_i,
  input wire logic [1:0] aux_fault_i,
  // detector results
  output logic [1:0] main12_good_o,
  output logic [1:0] main3_good_o,
  output logic [1:0] aux_good_o,
  output logic [1:0] main_fault_o,
  output logic [1:0] aux_fault_o
);
  // rails follow their enable, so a disabled rail never reads good
  always_ff @(posedge clock_i) begin
    main12_good_o <= main_enable_i & ~drop_i[1:0];
    main3_good_o <= main_enable_i & ~drop_i[3:2];
    aux_good_o <= aux_enable_i & ~drop_i[5:4];
  end
  // a fault stands only while commanded, so a clear pulse can find it gone
  assign main_fault_o = main_fault_i;
  assign aux_fault_o = aux_fault_i;
endmodule

// ---- bench/hpg_status_test.sv ----
/*
  self-checking bench of the hot-plug status block with a slot card model.
  assumes the shortened delay parameters set below and a 10 MHz clock.
*/
`timescale 1ns/1ns
module hpg_status_test;
  localparam int DLY = 20;
  localparam int HOLD = 5;
  localparam int DEB = 8;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ce_i = 1'b1;
  logic [1:0] men = 2'b00, aen = 2'b00, pres_n = 2'b11, force_n = 2'b11;
  logic [1:0] mflt = 2'b00, aflt = 2'b00, g12, g3, gx, fm, fx;
  logic [1:0] sg_oe, dg_oe, mf_oe, af_oe;
  logic [5:0] drop = 6'h00;
  logic int_oe, sys_oe, wr = 1'b0, rd = 1'b0, irq_o;
  logic [hpg_pkg::ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata_o;
  int bad_count = 0, checks_done = 0, cycles = 0;
  // clock and hang guard
  always #50 clock_i = ~clock_i;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      bad_count++;
      final_report;
    end
  end
  hpg_card i_card (.clock_i(clock_i), .main_enable_i(men), .aux_enable_i(aen),
    .drop_i(drop), .main_fault_i(mflt), .aux_fault_i(aflt), .main12_good_o(g12),
    .main3_good_o(g3), .aux_good_o(gx), .main_fault_o(fm), .aux_fault_o(fx));
  hpg_status #(.GOOD_DELAY_CYC(DLY), .GOOD_HOLD_CYC(HOLD), .DEBOUNCE_CYC(DEB)) i_dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i), .main_enable_i(men),
    .aux_rail_enable_i(aen), .card_present_n_i(pres_n), .force_on_n_i(force_n),
    .main12_good_i(g12), .main3_good_i(g3), .aux_rail_output_good_i(gx),
    .main_fault_i(fm), .aux_fault_i(fx), .slot_good_n_oe_o(sg_oe),
    .delayed_slot_good_n_oe_o(dg_oe), .main_fault_n_oe_o(mf_oe),
    .aux_fault_n_oe_o(af_oe), .interrupt_n_oe_o(int_oe), .system_good_oe_o(sys_oe),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o),
    .irq_o(irq_o));
  // wait n edges, then sample once the edge has settled
  task wt(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task bus_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock_i);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task bus_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_i);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock_i);
    rd <= 1'b0;
    #1;
    d = rdata_o;
  endtask
  task t_power_up;
    int n;
    logic [31:0] d;
    @(posedge clock_i);
    pres_n <= 2'b00;
    men <= 2'b11;
    aen <= 2'b11;
    n = 0;
    wt(1);
    while (sg_oe[0] !== 1'b1 && n < 60) begin
      wt(1);
      n++;
    end
    chk(n >= DEB && n <= DEB + 6, 1'b1, "slot good vs debounce");
    n = 0;
    while (dg_oe[0] !== 1'b1 && n < 60) begin
      wt(1);
      n++;
    end
    chk(n >= DLY - 2 && n <= DLY + 2, 1'b1, "delayed good timing");
    // live state: both slots present, good and delayed good, no flags
    bus_read(hpg_pkg::OFS_STATE, d);
    chk(d, 32'h0000003F, "live state after power-up");
    bus_read(hpg_pkg::OFS_STATUS, d);
    chk(d, 32'h00000030, "delayed good events");
    $display("test power_up done");
  endtask
  task t_drop;
    @(posedge clock_i);
    drop <= 6'h01;
    wt(5);
    chk(dg_oe[0], 1'b0, "delayed good held on rail loss");
    chk(sg_oe[0], 1'b1, "slot good fell with delayed good");
    wt(HOLD + 3);
    chk(sg_oe[0], 1'b0, "slot good held on rail loss");
    @(posedge clock_i);
    drop <= 6'h00;
    // an old count must not bring delayed good back early
    wt(DLY - 2);
    chk(dg_oe[0], 1'b0, "delayed good early");
    wt(12);
    chk(dg_oe[0], 1'b1, "delayed good missing");
    @(posedge clock_i);
    aen <= 2'b10;
    wt(5);
    chk(dg_oe[0], 1'b0, "delayed good on aux enable fall");
    @(posedge clock_i);
    aen <= 2'b11;
    wt(DLY + 8);
    $display("test drop done");
  endtask
  task t_sysgood;
    for (int i = 0; i < 6; i++) begin
      @(posedge clock_i);
      drop <= 6'h01 << i;
      wt(6);
      chk(sys_oe, 1'b1, "system good not pulled low");
      @(posedge clock_i);
      drop <= 6'h00;
      wt(6);
      chk(sys_oe, 1'b0, "system good not released");
    end
    $display("test sysgood done");
  endtask
  task t_fault;
    logic [31:0] d;
    bus_read(hpg_pkg::OFS_MASK, d);
    chk(d, {26'h0, hpg_pkg::MASK_RESET}, "mask reset value");
    bus_write(hpg_pkg::OFS_MASK, 32'h05);
    @(posedge clock_i);
    mflt <= 2'b01;
    aflt <= 2'b01;
    wt(6);
    chk({mf_oe[0], af_oe[0], int_oe, irq_o}, 4'hF, "fault not flagged");
    @(posedge clock_i);
    mflt <= 2'b00;
    aflt <= 2'b00;
    bus_read(hpg_pkg::OFS_STATUS, d);
    chk(d & 32'h0F, 32'h05, "status events");
    chk(int_oe, 1'b1, "interrupt lost with fault input");
    @(posedge clock_i);
    men <= 2'b10;
    wt(4);
    @(posedge clock_i);
    men <= 2'b11;
    wt(5);
    chk({mf_oe[0], af_oe[0], int_oe}, 3'h3, "main clear only");
    @(posedge clock_i);
    aen <= 2'b10;
    wt(7);
    @(posedge clock_i);
    aen <= 2'b11;
    wt(5);
    chk({af_oe[0], int_oe, irq_o}, 3'h1, "aux clear");
    bus_write(hpg_pkg::OFS_STATUS, 32'h3F);
    wt(2);
    chk(irq_o, 1'b0, "irq after status clear");
    bus_read(4'hC, d);
    chk(d, 32'h0, "unmapped read");
    // a low clock enable must swallow a register write
    @(posedge clock_i);
    ce_i <= 1'b0;
    bus_write(hpg_pkg::OFS_MASK, 32'h3F);
    @(posedge clock_i);
    ce_i <= 1'b1;
    bus_read(hpg_pkg::OFS_MASK, d);
    chk(d, 32'h05, "write taken with enable low");
    wt(DLY + 8);
    $display("test fault done");
  endtask
  task t_force;
    @(posedge clock_i);
    drop <= 6'h02;
    mflt <= 2'b10;
    wt(6);
    chk({sys_oe, int_oe}, 2'h3, "slot B loss and fault");
    @(posedge clock_i);
    force_n <= 2'b00;
    wt(6);
    chk({sg_oe, dg_oe}, 4'hF, "override goods");
    chk({mf_oe, int_oe, sys_oe}, 4'h0, "override releases");
    @(posedge clock_i);
    force_n <= 2'b11;
    drop <= 6'h00;
    mflt <= 2'b00;
    $display("test force done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    wt(4);
    t_power_up;
    t_drop;
    t_sysgood;
    t_fault;
    t_force;
    wt(4);
    final_report;
  end
endmodule

// ---- common/hpg_pkg.sv ----
/*
  constants shared by the hot-plug power-good status block: timing figures,
  cycle counts derived from the 10 MHz clock, register offsets and bit layouts.
  assumes one clock of period CLK_PERIOD_NS drives the whole block.
*/
package hpg_pkg;
  // clock
  localparam int unsigned CLK_PERIOD_NS = 100;
  // documented times, in nanoseconds
  localparam int unsigned GOOD_DELAY_NS = 164_000_000; // delayed power-good lag
  localparam int unsigned GOOD_HOLD_NS = 1_000_000;    // slot good outlives delayed good
  localparam int unsigned DEBOUNCE_NS = 10_000_000;    // card-present debounce
  localparam int unsigned MAIN_CLR_NS = 200;           // least low pulse, main enable
  localparam int unsigned AUX_CLR_NS = 500;            // least low pulse, aux enable
  // least times round up to whole cycles
  localparam int unsigned GOOD_DELAY_CYC = (GOOD_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned GOOD_HOLD_CYC = (GOOD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MAIN_CLR_CYC = (MAIN_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned AUX_CLR_CYC = (AUX_CLR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 21;  // holds the longest count
  localparam int PULSE_W = 3; // holds the enable low-pulse counts
  // register bus
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0; // sticky events, write one to clear
  localparam logic [ADDR_W-1:0] OFS_MASK = 4'h4;   // interrupt mask, same layout
  localparam logic [ADDR_W-1:0] OFS_STATE = 4'h8;  // live state, read only
  localparam int EV_W = 6;
  localparam logic [EV_W-1:0] MASK_RESET = 6'h00;
  // event bits: [1:0] main fault set, [3:2] aux fault set, [5:4] delayed good rose
  localparam int EV_MAIN = 0;
  localparam int EV_AUX = 2;
  localparam int EV_DLY = 4;
  // synchronised input vector, two bits (slot B, slot A) per group
  localparam int IX_MAIN_EN = 0;
  localparam int IX_AUX_EN = 2;
  localparam int IX_PRESENT_N = 4;
  localparam int IX_FORCE_N = 6;
  localparam int IX_M12_GOOD = 8;
  localparam int IX_M3_GOOD = 10;
  localparam int IX_AUX_GOOD = 12;
  localparam int IX_MAIN_FLT = 14;
  localparam int IX_AUX_FLT = 16;
  localparam int IN_W = 18;
endpackage

// ---- src/hpg_status.sv ----
/*
  status logic of a dual-slot hot-plug power controller: delayed and plain
  slot power-good, system power-good, fault flags, interrupt pin, and a small
  register file with a maskable interrupt.
  assumes rail good and fault flags come from analog detectors in another
  clock domain; open-drain pins are resolved outside, each *_oe_o pulls low.
*/
`timescale 1ns/1ns
module hpg_status #(
  parameter int unsigned GOOD_DELAY_CYC = hpg_pkg::GOOD_DELAY_CYC,
  parameter int unsigned GOOD_HOLD_CYC = hpg_pkg::GOOD_HOLD_CYC,
  parameter int unsigned DEBOUNCE_CYC = hpg_pkg::DEBOUNCE_CYC
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // slot pins, bit 0 slot A, bit 1 slot B
  input wire logic [1:0] main_enable_i,
  input wire logic [1:0] aux_rail_enable_i,
  input wire logic [1:0] card_present_n_i,
  input wire logic [1:0] force_on_n_i,
  // detector results
  input wire logic [1:0] main12_good_i,
  input wire logic [1:0] main3_good_i,
  input wire logic [1:0] aux_rail_output_good_i,
  input wire logic [1:0] main_fault_i,
  input wire logic [1:0] aux_fault_i,
  // open-drain pins, high pulls the pin low
  output logic [1:0] slot_good_n_oe_o,
  output logic [1:0] delayed_slot_good_n_oe_o,
  output logic [1:0] main_fault_n_oe_o,
  output logic [1:0] aux_fault_n_oe_o,
  output logic interrupt_n_oe_o,
  output logic system_good_oe_o,
  // register port
  input wire logic [hpg_pkg::ADDR_W-1:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o
);
  localparam int CW = hpg_pkg::CNT_W;
  localparam int PW = hpg_pkg::PULSE_W;

  typedef struct packed {
    logic [hpg_pkg::IN_W-1:0] sync1;
    logic [hpg_pkg::IN_W-1:0] sync2;
    logic [1:0] main_en_q;
    logic [1:0] aux_en_q;
    logic [1:0] present;
    logic [1:0][CW-1:0] db_cnt;
    logic [1:0] good;
    logic [1:0] dly;
    logic [1:0][CW-1:0] dly_cnt;
    logic [1:0][CW-1:0] hold_cnt;
    logic [1:0] f_main;
    logic [1:0] f_aux;
    logic [1:0] arm_main;
    logic [1:0] arm_aux;
    logic [1:0][PW-1:0] lo_main;
    logic [1:0][PW-1:0] lo_aux;
    logic [1:0] good_oe;
    logic [1:0] dly_oe;
    logic [1:0] fm_oe;
    logic [1:0] fa_oe;
    logic int_oe;
    logic sys_oe;
    logic [hpg_pkg::EV_W-1:0] status;
    logic [hpg_pkg::EV_W-1:0] mask;
    logic [31:0] rdata;
    logic irq;
  } hpg_state_s;

  hpg_state_s st;
  hpg_state_s next_st;
  logic [1:0] rst_sync;
  logic rst_n;

  // true when a counter has run its full length
  function automatic logic hpg_done(input logic [CW-1:0] cnt, input int unsigned lim);
    hpg_done = (cnt >= CW'(lim - 1));
  endfunction

  // reset is asserted at once and released through two flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // synchronised views of the pins
  logic [hpg_pkg::IN_W-1:0] pins;
  logic [1:0] main_en, aux_en, present_raw, force_on, rail_main, rail_aux, flt_m, flt_a;
  assign pins = {aux_fault_i, main_fault_i, aux_rail_output_good_i, main3_good_i,
                 main12_good_i, force_on_n_i, card_present_n_i, aux_rail_enable_i,
                 main_enable_i};
  assign main_en = st.sync2[hpg_pkg::IX_MAIN_EN +: 2];
  assign aux_en = st.sync2[hpg_pkg::IX_AUX_EN +: 2];
  assign present_raw = ~st.sync2[hpg_pkg::IX_PRESENT_N +: 2];
  assign force_on = ~st.sync2[hpg_pkg::IX_FORCE_N +: 2];
  assign rail_main = st.sync2[hpg_pkg::IX_M12_GOOD +: 2] & st.sync2[hpg_pkg::IX_M3_GOOD +: 2];
  assign rail_aux = st.sync2[hpg_pkg::IX_AUX_GOOD +: 2];
  assign flt_m = st.sync2[hpg_pkg::IX_MAIN_FLT +: 2];
  assign flt_a = st.sync2[hpg_pkg::IX_AUX_FLT +: 2];

  logic [1:0] fall_main, fall_aux, pwr_ok, sys_low;
  logic [hpg_pkg::EV_W-1:0] ev, w1c;
  assign fall_main = st.main_en_q & ~main_en;
  assign fall_aux = st.aux_en_q & ~aux_en;

  // next-state logic for the whole block
  always_comb begin
    next_st = st;
    next_st.sync1 = pins;
    next_st.sync2 = st.sync1;
    next_st.main_en_q = main_en;
    next_st.aux_en_q = aux_en;
    ev = '0;
    pwr_ok = '0;
    sys_low = '0;
    for (int s = 0; s < 2; s++) begin
      // removal drops presence at once, insertion waits out the bounce
      if (!present_raw[s]) begin
        next_st.present[s] = 1'b0;
        next_st.db_cnt[s] = '0;
      end else if (!st.present[s]) begin
        next_st.db_cnt[s] = st.db_cnt[s] + CW'(1);
        if (hpg_done(st.db_cnt[s], DEBOUNCE_CYC)) begin
          next_st.present[s] = 1'b1;
        end
      end
      // rail flags stick until the enable pulse clears them; override defeats protection
      if (!force_on[s]) begin
        if (flt_m[s] && !st.f_main[s]) begin
          ev[hpg_pkg::EV_MAIN + s] = 1'b1;
        end
        if (flt_a[s] && !st.f_aux[s]) begin
          ev[hpg_pkg::EV_AUX + s] = 1'b1;
        end
        next_st.f_main[s] = st.f_main[s] | flt_m[s];
        next_st.f_aux[s] = st.f_aux[s] | flt_a[s];
      end
      // each enable clears only its own rail's flag, after a long enough low pulse
      next_st.arm_main[s] = (st.arm_main[s] | fall_main[s]) & ~main_en[s];
      next_st.lo_main[s] = next_st.arm_main[s] ? st.lo_main[s] + PW'(1) : '0;
      if (st.arm_main[s] && !main_en[s] && st.lo_main[s] >= PW'(hpg_pkg::MAIN_CLR_CYC - 1)
          && !flt_m[s]) begin
        next_st.f_main[s] = 1'b0;
        next_st.arm_main[s] = 1'b0;
      end
      next_st.arm_aux[s] = (st.arm_aux[s] | fall_aux[s]) & ~aux_en[s];
      next_st.lo_aux[s] = next_st.arm_aux[s] ? st.lo_aux[s] + PW'(1) : '0;
      if (st.arm_aux[s] && !aux_en[s] && st.lo_aux[s] >= PW'(hpg_pkg::AUX_CLR_CYC - 1)
          && !flt_a[s]) begin
        next_st.f_aux[s] = 1'b0;
        next_st.arm_aux[s] = 1'b0;
      end
      // slot power is good when the card is present, a rail is enabled, every enabled rail is up and no flag stands
      pwr_ok[s] = st.present[s] & (main_en[s] | aux_en[s]) & (~main_en[s] | rail_main[s])
                  & (~aux_en[s] | rail_aux[s]) & ~st.f_main[s] & ~st.f_aux[s];
      // slot good and delayed good sequencing
      if (force_on[s]) begin
        next_st.good[s] = 1'b1;
        next_st.dly[s] = 1'b1;
        next_st.dly_cnt[s] = '0;
        next_st.hold_cnt[s] = '0;
      end else if (!st.present[s]) begin
        next_st.good[s] = 1'b0;
        next_st.dly[s] = 1'b0;
        next_st.dly_cnt[s] = '0;
        next_st.hold_cnt[s] = '0;
      end else if (pwr_ok[s]) begin
        next_st.good[s] = 1'b1;
        next_st.hold_cnt[s] = '0;
        if (fall_main[s] || fall_aux[s]) begin
          next_st.dly[s] = 1'b0;
          next_st.dly_cnt[s] = '0;
        end else if (st.good[s] && !st.dly[s]) begin
          next_st.dly_cnt[s] = st.dly_cnt[s] + CW'(1);
          if (hpg_done(st.dly_cnt[s], GOOD_DELAY_CYC)) begin
            next_st.dly[s] = 1'b1;
          end
        end
      end else begin
        // power-down: delayed good goes first, slot good follows the hold
        next_st.dly[s] = 1'b0;
        next_st.dly_cnt[s] = '0;
        if (st.good[s]) begin
          next_st.hold_cnt[s] = st.hold_cnt[s] + CW'(1);
          if (hpg_done(st.hold_cnt[s], GOOD_HOLD_CYC)) begin
            next_st.good[s] = 1'b0;
            next_st.hold_cnt[s] = '0;
          end
        end
      end
      if (next_st.dly[s] && !st.dly[s]) begin
        ev[hpg_pkg::EV_DLY + s] = 1'b1;
      end
      // system good pull-down terms, main and aux per slot
      sys_low[s] = st.present[s] & ~force_on[s]
                   & ((main_en[s] & ~rail_main[s])
                   | (aux_en[s] & ~rail_aux[s]));
    end
    // pins pull low while asserted; override releases faults
    next_st.good_oe = next_st.good;
    next_st.dly_oe = next_st.dly;
    next_st.fm_oe = next_st.f_main & ~force_on;
    next_st.fa_oe = next_st.f_aux & ~force_on;
    next_st.int_oe = |((next_st.f_main | next_st.f_aux) & ~force_on);
    next_st.sys_oe = |sys_low & ~|force_on;
    // registers: a new event wins over a clear in the same cycle
    w1c = (wr_i && addr_i == hpg_pkg::OFS_STATUS) ? wdata_i[hpg_pkg::EV_W-1:0] : '0;
    next_st.status = (st.status & ~w1c) | ev;
    if (wr_i && addr_i == hpg_pkg::OFS_MASK) begin
      next_st.mask = wdata_i[hpg_pkg::EV_W-1:0];
    end
    next_st.irq = |(next_st.status & next_st.mask);
    next_st.rdata = '0;
    if (rd_i) begin
      unique case (addr_i)
        hpg_pkg::OFS_STATUS: next_st.rdata = {26'h0, st.status};
        hpg_pkg::OFS_MASK: next_st.rdata = {26'h0, st.mask};
        hpg_pkg::OFS_STATE: next_st.rdata = {20'h0, st.sys_oe, st.int_oe, st.f_aux,
                                             st.f_main, st.dly, st.good, st.present};
        default: next_st.rdata = '0;
      endcase
    end
  end

  // one register for all state; a low enable freezes it
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mask <= hpg_pkg::MASK_RESET;
    end else if (ce_i) begin
      st <= next_st;
    end
  end

  assign slot_good_n_oe_o = st.good_oe;
  assign delayed_slot_good_n_oe_o = st.dly_oe;
  assign main_fault_n_oe_o = st.fm_oe;
  assign aux_fault_n_oe_o = st.fa_oe;
  assign interrupt_n_oe_o = st.int_oe;
  assign system_good_oe_o = st.sys_oe;
  assign rdata_o = st.rdata;
  assign irq_o = st.irq;

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  sequence s_dly_rise(s); ce_i && !st.dly[s] && next_st.dly[s] && !force_on[s]; endsequence
  sequence s_power_down(s);
    ce_i && st.dly[s] && !pwr_ok[s] && st.present[s] && !force_on[s];
  endsequence

  chk_dly_after_count: assert property (s_dly_rise(0) |->
    hpg_done(st.dly_cnt[0], GOOD_DELAY_CYC) && st.good[0])
    else $error("delayed good rose before its count ran out");
  chk_dly_edge_drop: assert property (ce_i && (fall_main[0] || fall_aux[0])
    && !force_on[0] |=> !st.dly[0])
    else $error("delayed good survived an enable falling edge");
  chk_good_outlives: assert property (s_power_down(0) |=>
    !st.dly[0] && st.good[0]) else $error("slot good dropped with delayed good");
  chk_sys_pull: assert property (ce_i && |sys_low && !(|force_on) |=>
    system_good_oe_o) else $error("system good not pulled low");
  chk_sys_release: assert property (ce_i && !(|sys_low) |=> !system_good_oe_o)
    else $error("system good pulled low without cause");
  chk_int_fault: assert property (ce_i && |(next_st.f_main & ~force_on) |=>
    interrupt_n_oe_o) else $error("fault stands but interrupt released");
  chk_int_clear: assert property (ce_i && !(|next_st.f_main) && !(|next_st.f_aux) |=>
    !interrupt_n_oe_o) else $error("interrupt held with no fault");
  chk_main_clear: assert property (ce_i && st.f_main[0] && !next_st.f_main[0] |->
    !$past(main_en[0], 1)) else $error("main fault cleared without low pulse");
  chk_aux_clear: assert property (ce_i && st.f_aux[0] && !next_st.f_aux[0] |->
    !aux_en[0] && st.lo_aux[0] >= PW'(hpg_pkg::AUX_CLR_CYC - 1))
    else $error("aux fault cleared too early");
  chk_force_out: assert property (ce_i && force_on[0] |=> st.dly[0] && st.good[0]
    && !main_fault_n_oe_o[0] && !system_good_oe_o) else $error("override not honoured");
  chk_present_wait: assert property (ce_i && !st.present[1] && next_st.present[1] |->
    hpg_done(st.db_cnt[1], DEBOUNCE_CYC)) else $error("card present without debounce");
  chk_status_set: assert property (ce_i && |ev |=> (st.status & $past(ev)) == $past(ev))
    else $error("event lost against a clear");
endmodule
